// ===== hdl/pdfg_pin_ctrl.sv
// Port D/E/F/G pin function, direction, pull-up and driver control with a Wishbone slave.
// Assumes pins pass through external pads; spi/serial cores supply their output data.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pdfg_pin_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // Port D pins
    input  wire logic [5:0]  pd_in_i,
    output logic      [5:0]  pd_out_o,
    output logic      [5:0]  pd_oe_o,
    output logic      [5:0]  pd_pullup_o,
    // Peripheral-side signals
    input  wire logic        mosi_out_i,
    input  wire logic        sck_out_i,
    input  wire logic        miso_out_i,
    input  wire logic        txd_i,
    output logic             miso_in_o,
    output logic             rxd_o,
    output logic             nmi_in_o,
    output logic             irq_o,
    // Port E, F, G pins
    input  wire logic [3:0]  pe_in_i,
    input  wire logic [6:0]  pf_in_i,
    output logic      [6:0]  pf_out_o,
    output logic      [6:0]  pf_oe_o,
    input  wire logic [7:0]  pg_in_i,
    output logic      [7:0]  pg_out_o,
    output logic      [7:0]  pg_oe_o,
    input  wire logic [7:0]  pg_alt_i
);
    // =========================================================================
    // Registers
    // =========================================================================
    logic [7:0] d_dir;
    logic [7:0] d_func;
    logic [7:0] d_drv;
    logic [7:0] d_data;
    logic [7:0] f_data;
    logic [7:0] f_dir;
    logic [7:0] f_pend;
    logic [7:0] f_ien;
    logic [7:0] g_data;
    logic [7:0] g_dir;
    logic [7:0] g_csen;
    logic [7:0] periph;
    logic       ack;
    // Pin synchronisers: three stages, change counted when stages 2 and 3 agree
    logic [25:0] sync1;
    logic [25:0] sync2;
    logic [25:0] sync3;
    logic [25:0] pin_stable;
    logic [25:0] next_stable;
    wire  [25:0] raw_pins = {pg_in_i, pf_in_i, pe_in_i, pd_in_i, 1'b0};
    wire  [5:0]  pd_s = pin_stable[6:1];
    wire  [3:0]  pe_s = pin_stable[10:7];
    wire  [6:0]  pf_s = pin_stable[17:11];
    wire  [7:0]  pg_s = pin_stable[25:18];
    logic [6:0]  pf_prev;
    logic        irq_prev;

    // =========================================================================
    // Bus decode
    // =========================================================================
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    wire req      = wb_cyc_i & wb_stb_i & ~ack;
    wire wr_lane  = req & wb_we_i & wb_sel_i[0];
    wire [7:0] wd = wb_dat_i[7:0];
    wire mapped   = hit(wb_adr_i, pdfg_pkg::ADDR_D_DIR)  | hit(wb_adr_i, pdfg_pkg::ADDR_D_FUNC)
                  | hit(wb_adr_i, pdfg_pkg::ADDR_D_DRV)  | hit(wb_adr_i, pdfg_pkg::ADDR_D_DATA)
                  | hit(wb_adr_i, pdfg_pkg::ADDR_E_DATA) | hit(wb_adr_i, pdfg_pkg::ADDR_F_DATA)
                  | hit(wb_adr_i, pdfg_pkg::ADDR_F_DIR)  | hit(wb_adr_i, pdfg_pkg::ADDR_F_PEND)
                  | hit(wb_adr_i, pdfg_pkg::ADDR_F_IEN)  | hit(wb_adr_i, pdfg_pkg::ADDR_G_DATA)
                  | hit(wb_adr_i, pdfg_pkg::ADDR_G_DIR)  | hit(wb_adr_i, pdfg_pkg::ADDR_G_CSEN)
                  | hit(wb_adr_i, pdfg_pkg::ADDR_PERIPH);
    wire wr_ok    = wr_lane & mapped;
    wire pend_rd  = req & ~wb_we_i & hit(wb_adr_i, pdfg_pkg::ADDR_F_PEND);

    // =========================================================================
    // Port D function selection
    // =========================================================================
    wire spi_enable_bit    = periph[pdfg_pkg::PER_SPE];
    wire master_select_bit   = periph[pdfg_pkg::PER_MASTER_SELECT_BIT];
    wire te     = periph[pdfg_pkg::PER_TE];
    wire re     = periph[pdfg_pkg::PER_RE];
    wire swmode = d_func[pdfg_pkg::FUNC_SW_MODE];
    wire spi_34   = spi_enable_bit;
    wire nmi_sel  = d_func[pdfg_pkg::FUNC_NMI_SEL] & ~d_func[pdfg_pkg::FUNC_MISO_SEL];
    wire miso_sel = d_func[pdfg_pkg::FUNC_NMI_SEL] & d_func[pdfg_pkg::FUNC_MISO_SEL] & spi_enable_bit;
    wire irq_sel  = d_func[pdfg_pkg::FUNC_IRQ_SEL] & ~d_func[pdfg_pkg::FUNC_IRQ_ALT];
    wire ss_sel   = d_func[pdfg_pkg::FUNC_IRQ_SEL] & d_func[pdfg_pkg::FUNC_IRQ_ALT] & spi_enable_bit;
    wire tx_pd1   = te;
    wire rx_pd1   = swmode & re;
    wire rx_pd0   = ~swmode & re;
    wire pd1_alt  = tx_pd1 | rx_pd1;
    wire spi_oe   = master_select_bit;

    // Per-pin output enable, pull-up, and output value before driver select
    logic [5:0] oe_raw;
    logic [5:0] pu_raw;
    logic [5:0] dv_raw;
    always_comb begin
        oe_raw = d_dir[5:0];
        pu_raw = d_dir[5:0] & ~d_dir[5:0] | ~d_dir[5:0] & 6'h00 | d_dir[5:0];
        dv_raw = d_data[5:0];
        if (irq_sel) begin
            oe_raw[5] = 1'b0;
            pu_raw[5] = 1'b1;
        end else if (ss_sel) begin
            oe_raw[5] = 1'b0 | d_dir[5];
            pu_raw[5] = 1'b0;
        end
        if (spi_34) begin
            oe_raw[4] = spi_oe | d_dir[4];
            oe_raw[3] = spi_oe | d_dir[3];
            pu_raw[4] = 1'b0;
            pu_raw[3] = 1'b0;
            dv_raw[4] = mosi_out_i;
            dv_raw[3] = sck_out_i;
        end
        if (nmi_sel) begin
            oe_raw[2] = 1'b0;
            pu_raw[2] = 1'b1;
        end else if (miso_sel) begin
            oe_raw[2] = spi_oe | d_dir[2];
            pu_raw[2] = 1'b0;
            dv_raw[2] = miso_out_i;
        end
        if (pd1_alt) begin
            oe_raw[1] = tx_pd1;
            pu_raw[1] = 1'b0;
            dv_raw[1] = txd_i;
        end
        if (rx_pd0) begin
            oe_raw[0] = 1'b0;
            pu_raw[0] = 1'b0;
        end
    end

    // Open-drain: drive only lows when selected, only on output pins
    logic [5:0] od_oe;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            od_oe[i] = oe_raw[i] & (~d_drv[i] | ~dv_raw[i]);
        end
    end

    // =========================================================================
    // Port F and G direction
    // =========================================================================
    wire [6:0] f_oe = f_dir[6:0] & ~f_ien[6:0];
    wire [7:0] g_oe = g_dir | g_csen;
    wire [7:0] g_dv = (g_csen & pg_alt_i) | (~g_csen & g_data);

    // Edge events on enabled port F lines and the port D maskable request
    wire [6:0] f_event = f_ien[6:0] & pf_prev & ~pf_s;
    wire       d_event = irq_sel & irq_prev & ~pd_s[5];
    wire [7:0] set_pend = {d_event, f_event};
    wire [7:0] en_mask  = {irq_sel, f_ien[6:0]};

    // =========================================================================
    // Read mux
    // =========================================================================
    logic [7:0] rd;
    always_comb begin
        case (wb_adr_i)
            pdfg_pkg::ADDR_D_DIR:  rd = d_dir;
            pdfg_pkg::ADDR_D_FUNC: rd = d_func;
            pdfg_pkg::ADDR_D_DRV:  rd = d_drv;
            pdfg_pkg::ADDR_D_DATA: rd = {2'b00, pd_s};
            pdfg_pkg::ADDR_E_DATA: rd = {4'h0, pe_s};
            pdfg_pkg::ADDR_F_DATA: rd = {1'b0, (f_oe & f_data[6:0]) | (~f_oe & pf_s)};
            pdfg_pkg::ADDR_F_DIR:  rd = f_dir;
            pdfg_pkg::ADDR_F_PEND: rd = f_pend;
            pdfg_pkg::ADDR_F_IEN:  rd = f_ien;
            pdfg_pkg::ADDR_G_DATA: rd = (g_oe & g_data) | (~g_oe & pg_s);
            pdfg_pkg::ADDR_G_DIR:  rd = g_dir;
            pdfg_pkg::ADDR_G_CSEN: rd = g_csen;
            pdfg_pkg::ADDR_PERIPH: rd = periph;
            default:               rd = 8'h00;
        endcase
    end

    // =========================================================================
    // Sequential
    // =========================================================================
    always_comb begin
        for (int i = 0; i < 26; i++) begin
            next_stable[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_stable[i];
        end
    end

    always_ff @(posedge clk_i) begin
        sync1 <= raw_pins;
        sync2 <= sync1;
        sync3 <= sync2;
        if (rst_i) begin
            pin_stable <= '0;
            pf_prev    <= 7'h00;
            irq_prev   <= 1'b0;
        end else begin
            pin_stable <= next_stable;
            pf_prev    <= pf_s;
            irq_prev   <= pd_s[5];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack      <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack      <= req & mapped;
            wb_err_o <= req & ~mapped;
            wb_dat_o <= {24'h00_0000, rd};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            d_dir  <= pdfg_pkg::RST_ZERO;
            d_func <= pdfg_pkg::RST_D_FUNC;
            d_drv  <= pdfg_pkg::RST_ZERO;
            d_data <= pdfg_pkg::RST_ZERO;
            f_data <= pdfg_pkg::RST_ZERO;
            f_dir  <= pdfg_pkg::RST_ZERO;
            f_ien  <= pdfg_pkg::RST_ZERO;
            g_data <= pdfg_pkg::RST_ZERO;
            g_dir  <= pdfg_pkg::RST_ZERO;
            g_csen <= pdfg_pkg::RST_ZERO;
            periph <= pdfg_pkg::RST_ZERO;
        end else if (wr_ok) begin
            case (wb_adr_i)
                pdfg_pkg::ADDR_D_DIR:  d_dir  <= wd & pdfg_pkg::MASK_D_DIR;
                pdfg_pkg::ADDR_D_FUNC: d_func <= wd & pdfg_pkg::MASK_D_FUNC;
                pdfg_pkg::ADDR_D_DRV:  d_drv  <= wd & pdfg_pkg::MASK_D_DRV;
                pdfg_pkg::ADDR_D_DATA: d_data <= wd & pdfg_pkg::MASK_D_DIR;
                pdfg_pkg::ADDR_F_DATA: f_data <= wd & pdfg_pkg::MASK_F;
                pdfg_pkg::ADDR_F_DIR:  f_dir  <= wd & pdfg_pkg::MASK_F;
                pdfg_pkg::ADDR_F_IEN:  f_ien  <= wd & pdfg_pkg::MASK_F;
                pdfg_pkg::ADDR_G_DATA: g_data <= wd;
                pdfg_pkg::ADDR_G_DIR:  g_dir  <= wd & pdfg_pkg::MASK_G_DIR;
                pdfg_pkg::ADDR_G_CSEN: g_csen <= wd;
                pdfg_pkg::ADDR_PERIPH: periph <= wd & pdfg_pkg::MASK_E;
                default:               ;
            endcase
        end
    end

    // Pending: a read while a request is up clears all bits; new events win
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            f_pend <= pdfg_pkg::RST_ZERO;
        end else if (pend_rd && irq_o) begin
            f_pend <= set_pend;
        end else begin
            f_pend <= f_pend | set_pend;
        end
    end

    // =========================================================================
    // Outputs
    // =========================================================================
    assign wb_ack_o    = ack;
    assign pd_out_o    = dv_raw;
    assign pd_oe_o     = od_oe;
    assign pd_pullup_o = pu_raw & ~oe_raw;
    assign nmi_in_o    = nmi_sel ? pd_s[2] : 1'b1;
    assign miso_in_o   = miso_sel ? pd_s[2] : 1'b1;
    assign rxd_o       = rx_pd0 ? pd_s[0] : (rx_pd1 ? (te ? txd_i : pd_s[1]) : 1'b1);
    assign irq_o       = |(f_pend & en_mask);
    assign pf_out_o    = f_data[6:0];
    assign pf_oe_o     = f_oe;
    assign pg_out_o    = g_dv;
    assign pg_oe_o     = g_oe;
endmodule : pdfg_pin_ctrl
`default_nettype wire

// ===== hdl/pdfg_pkg.sv
// Package for the port D/E/F/G pin control block: register map, reset values, field positions.
// Assumes a classic Wishbone slave with 8-bit data and byte word addressing on a 32-bit bus.
package pdfg_pkg;
    // =========================================================================
    // Register offsets (byte addresses, one aligned word each)
    // =========================================================================
    localparam logic [7:0] ADDR_D_DIR      = 8'h00;
    localparam logic [7:0] ADDR_D_FUNC     = 8'h04;
    localparam logic [7:0] ADDR_D_DRV      = 8'h08;
    localparam logic [7:0] ADDR_D_DATA     = 8'h0C;
    localparam logic [7:0] ADDR_E_DATA     = 8'h10;
    localparam logic [7:0] ADDR_F_DATA     = 8'h14;
    localparam logic [7:0] ADDR_F_DIR      = 8'h18;
    localparam logic [7:0] ADDR_F_PEND     = 8'h1C;
    localparam logic [7:0] ADDR_F_IEN      = 8'h20;
    localparam logic [7:0] ADDR_G_DATA     = 8'h24;
    localparam logic [7:0] ADDR_G_DIR      = 8'h28;
    localparam logic [7:0] ADDR_G_CSEN     = 8'h2C;
    localparam logic [7:0] ADDR_PERIPH     = 8'h30;
    // =========================================================================
    // Reset values and implemented-bit masks
    // =========================================================================
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_D_FUNC      = 8'h3C;
    localparam logic [7:0] MASK_D_DIR      = 8'h3F;
    localparam logic [7:0] MASK_D_FUNC     = 8'h3D;
    localparam logic [7:0] MASK_D_DRV      = 8'h7F;
    localparam logic [7:0] MASK_E          = 8'h0F;
    localparam logic [7:0] MASK_F          = 8'h7F;
    localparam logic [7:0] MASK_G_DIR      = 8'h7F;
    // =========================================================================
    // Field positions
    // =========================================================================
    localparam int FUNC_IRQ_SEL  = 5;
    localparam int FUNC_IRQ_ALT  = 4;
    localparam int FUNC_NMI_SEL  = 3;
    localparam int FUNC_MISO_SEL = 2;
    localparam int FUNC_SW_MODE  = 0;
    localparam int PEND_D_IRQ    = 7;
    localparam int PER_SPE       = 0;
    localparam int PER_MASTER_SELECT_BIT      = 1;
    localparam int PER_TE        = 2;
    localparam int PER_RE        = 3;
endpackage : pdfg_pkg

// ===== verif/pdfg_assertions.sv
// Checker for the port D/E/F/G pin control block: bus answers and port D pin functions.
// Shadows the few control bits it needs at the edge that samples ack, one edge after the block writes them; pin checks skip ack cycles.
`timescale 1ns/1ps
`default_nettype none
module pdfg_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic [5:0]  pd_out_o,
    input wire logic [5:0]  pd_oe_o,
    input wire logic [5:0]  pd_pullup_o,
    input wire logic        mosi_out_i,
    input wire logic        txd_i,
    input wire logic        miso_in_o,
    input wire logic        nmi_in_o,
    input wire logic        irq_o
);
    // =========================================================================
    // Shadow of control bits
    // =========================================================================
    logic [7:0] ddir, dfn, ddrv, per;
    wire        wr   = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire        spi_enable_bit  = per[pdfg_pkg::PER_SPE];
    wire        master_select_bit = per[pdfg_pkg::PER_MASTER_SELECT_BIT];
    wire  [5:0] oden = ~(ddrv[5:0] & pd_out_o);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {ddir, ddrv, per, dfn} <= {24'h000000, pdfg_pkg::RST_D_FUNC};
        end else if (wr && wb_adr_i == pdfg_pkg::ADDR_D_DIR) begin
            ddir <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == pdfg_pkg::ADDR_D_FUNC) begin
            dfn <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == pdfg_pkg::ADDR_D_DRV) begin
            ddrv <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i == pdfg_pkg::ADDR_PERIPH) begin
            per <= wb_dat_i[7:0];
        end
    end
    // =========================================================================
    // Assertions
    // =========================================================================
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o != wb_err_o)
        else $error("bus request not answered in one cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DIR_BIT7: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == pdfg_pkg::ADDR_F_DIR ||
        wb_adr_i == pdfg_pkg::ADDR_G_DIR) |-> wb_dat_o[31:7] == 25'h0000000)
        else $error("direction bit 7 not zero");
    AST_PEND_CLEAR: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
        && wb_adr_i == pdfg_pkg::ADDR_F_PEND && irq_o |=> !irq_o)
        else $error("pending read did not clear");
    AST_SPI_PINS: assert property (!wb_ack_o && spi_enable_bit |-> pd_pullup_o[4:3] == 2'b00 && pd_out_o[4] == mosi_out_i
        && pd_oe_o[4:3] == (({2{master_select_bit}} | ddir[4:3]) & oden[4:3]))
        else $error("spi pins wrong");
    AST_GPIO_43: assert property (!wb_ack_o && !spi_enable_bit |-> pd_oe_o[4:3] == (ddir[4:3] & oden[4:3]))
        else $error("gpio enable wrong");
    AST_NMI_PIN: assert property (!wb_ack_o && dfn[3:2] == 2'b10 |-> pd_pullup_o[2] && !pd_oe_o[2])
        else $error("nmi pin wrong");
    AST_MISO_PIN: assert property (!wb_ack_o && spi_enable_bit && dfn[3:2] == 2'b11
        |-> !pd_pullup_o[2] && pd_oe_o[2] == ((master_select_bit | ddir[2]) & oden[2]))
        else $error("miso pin wrong");
    AST_IDLE_HIGH: assert property (!wb_ack_o && !dfn[3] |-> nmi_in_o && miso_in_o)
        else $error("unselected input not high");
    AST_RX_PULL: assert property (!wb_ack_o && !dfn[0] && per[pdfg_pkg::PER_RE] |-> !pd_pullup_o[0])
        else $error("receive pin pulled up");
    AST_TX_DRV: assert property (!wb_ack_o && !dfn[0] && per[pdfg_pkg::PER_TE]
        |-> pd_oe_o[1] == (!ddrv[1] || !txd_i))
        else $error("transmit driver wrong");
endmodule : pdfg_assertions
bind pdfg_pin_ctrl pdfg_assertions pdfg_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .pd_out_o(pd_out_o), .pd_oe_o(pd_oe_o),
    .pd_pullup_o(pd_pullup_o), .mosi_out_i(mosi_out_i), .txd_i(txd_i), .miso_in_o(miso_in_o),
    .nmi_in_o(nmi_in_o), .irq_o(irq_o));
`default_nettype wire

// ===== verif/pdfg_board.sv
// Board model for the port D and F pins: resolves each pin level.
// Assumes an outside source holds every line that the block releases.
`timescale 1ns/1ps
`default_nettype none
module pdfg_board (
    input  wire logic [5:0] pd_out_i,
    input  wire logic [5:0] pd_oe_i,
    input  wire logic [5:0] pd_ext_i,
    input  wire logic [6:0] pf_out_i,
    input  wire logic [6:0] pf_oe_i,
    input  wire logic [6:0] pf_ext_i,
    output logic      [5:0] pd_lvl_o,
    output logic      [6:0] pf_lvl_o
);
    // Driven bits follow the block, released bits follow the outside source
    assign pd_lvl_o = (pd_oe_i & pd_out_i) | (~pd_oe_i & pd_ext_i);
    assign pf_lvl_o = (pf_oe_i & pf_out_i) | (~pf_oe_i & pf_ext_i);
endmodule : pdfg_board
`default_nettype wire

// ===== verif/test_port_d_f_g_pin_control.sv
// Testbench for the port D/E/F/G pin control block: register map and pin functions.
// Assumes the board model resolves port D and F levels.
`timescale 1ns/1ps
`default_nettype none
module test_port_d_f_g_pin_control;
    logic        clk_i, rst_i, cyc, stb, we, ack, err, rerr, mosi, sck, miso, txd, miso_in, rxd, nmi_in, irq;
    logic [7:0]  adr, pg_in, pg_alt, pg_out, pg_oe;
    logic [31:0] wdat, rdat, dat_o;
    logic [3:0]  pe_in;
    logic [5:0]  pd_ext, pd_out, pd_oe, pd_pu, pd_lvl;
    logic [6:0]  pf_ext, pf_out, pf_oe, pf_lvl;
    logic [7:0]  maddr [3] = '{pdfg_pkg::ADDR_D_DIR, pdfg_pkg::ADDR_F_DIR, pdfg_pkg::ADDR_G_DIR};
    logic [7:0]  mexp [3]  = '{8'h3F, 8'h7F, 8'h7F};
    int          errors = 0;
    int          checked = 0;
    pdfg_pin_ctrl pdfg_pin_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .pd_in_i(pd_lvl), .pd_out_o(pd_out), .pd_oe_o(pd_oe), .pd_pullup_o(pd_pu), .mosi_out_i(mosi),
        .sck_out_i(sck), .miso_out_i(miso), .txd_i(txd), .miso_in_o(miso_in), .rxd_o(rxd), .nmi_in_o(nmi_in),
        .irq_o(irq), .pe_in_i(pe_in), .pf_in_i(pf_lvl), .pf_out_o(pf_out), .pf_oe_o(pf_oe), .pg_in_i(pg_in),
        .pg_out_o(pg_out), .pg_oe_o(pg_oe), .pg_alt_i(pg_alt));
    pdfg_board pdfg_board_i (.pd_out_i(pd_out), .pd_oe_i(pd_oe), .pd_ext_i(pd_ext), .pf_out_i(pf_out),
        .pf_oe_i(pf_oe), .pf_ext_i(pf_ext), .pd_lvl_o(pd_lvl), .pf_lvl_o(pf_lvl));
    // =========================================================================
    // Tasks
    // =========================================================================
    task automatic results();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        {rerr, rdat} = {err, dat_o};
        {cyc, stb, we} <= 3'b000;
        if (ack !== 1'b1 && err !== 1'b1) begin
            errors++;
            results();
        end
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        bus(a, 1'b0, 8'h00);
        chk(nm, rdat, {24'h000000, exp});
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask : wt
    // =========================================================================
    // Clock and sequence
    // =========================================================================
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {cyc, stb, we, mosi, sck, miso, txd, adr, wdat} = '0;
        {pd_ext, pf_ext, pe_in, pg_in, pg_alt} = {6'h3F, 7'h7F, 4'hA, 8'h5A, 8'hC3};
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            rd(8'(i * 4), (i == 1) ? 8'h3C : (i == 3) ? 8'h3F : (i == 4) ? 8'h0A : (i == 5) ? 8'h7F :
                (i == 9) ? 8'h5A : 8'h00, "reset value");
        end
        bus(8'h34, 1'b0, 8'h00);
        chk("unmapped error", {31'h00000000, rerr}, 32'h00000001);
        $display("test reset done");
        foreach (maddr[i]) begin
            bus(maddr[i], 1'b1, 8'hFF);
            rd(maddr[i], mexp[i], "masked readback");
        end
        bus(pdfg_pkg::ADDR_F_PEND, 1'b1, 8'hFF);
        rd(pdfg_pkg::ADDR_F_PEND, 8'h00, "pending write ignored");
        bus(pdfg_pkg::ADDR_F_DATA, 1'b1, 8'h55);
        wt(1);
        chk("port f drive", 32'({pf_oe, pf_out}), 32'h3FD5);
        bus(pdfg_pkg::ADDR_F_IEN, 1'b1, 8'h0F);
        wt(1);
        chk("irq overrides direction", 32'(pf_oe), 32'h00000070);
        $display("test registers done");
        bus(pdfg_pkg::ADDR_F_DIR, 1'b1, 8'h00);
        @(posedge clk_i);
        pf_ext <= 7'h7E;
        wt(6);
        chk("irq raised", 32'(irq), 32'h00000001);
        bus(pdfg_pkg::ADDR_F_IEN, 1'b1, 8'h00);
        wt(1);
        chk("irq masked", 32'(irq), 32'h00000000);
        bus(pdfg_pkg::ADDR_F_IEN, 1'b1, 8'h0F);
        rd(pdfg_pkg::ADDR_F_PEND, 8'h01, "pending line");
        wt(1);
        chk("irq cleared", 32'(irq), 32'h00000000);
        rd(pdfg_pkg::ADDR_F_PEND, 8'h00, "pending cleared");
        $display("test port f irq done");
        bus(pdfg_pkg::ADDR_D_DIR, 1'b1, 8'h00);
        bus(pdfg_pkg::ADDR_PERIPH, 1'b1, 8'h03);
        @(posedge clk_i);
        {mosi, sck} <= 2'b10;
        wt(1);
        chk("spi master pins", 32'({pd_pu[4:2], pd_oe[4:2], pd_out[4:3]}), 32'h0000001E);
        bus(pdfg_pkg::ADDR_D_DRV, 1'b1, 8'h08);
        @(posedge clk_i);
        sck <= 1'b1;
        wt(1);
        chk("open drain sck high", 32'(pd_oe[3]), 32'h00000000);
        bus(pdfg_pkg::ADDR_PERIPH, 1'b1, 8'h01);
        @(posedge clk_i);
        pd_ext <= 6'h3B;
        wt(5);
        chk("spi slave pins", 32'({pd_oe[4:2], miso_in}), 32'h00000000);
        bus(pdfg_pkg::ADDR_D_FUNC, 1'b1, 8'h38);
        wt(2);
        chk("nmi pin", 32'({pd_pu[2], pd_oe[2], nmi_in, miso_in}), 32'h00000009);
        bus(pdfg_pkg::ADDR_D_FUNC, 1'b1, 8'h30);
        wt(2);
        chk("nmi unselected", 32'(nmi_in), 32'h00000001);
        $display("test spi and nmi done");
        bus(pdfg_pkg::ADDR_PERIPH, 1'b1, 8'h0C);
        bus(pdfg_pkg::ADDR_D_DRV, 1'b1, 8'h02);
        @(posedge clk_i);
        {pd_ext, txd} <= {6'h3A, 1'b1};
        wt(5);
        chk("two wire receive", 32'({rxd, pd_pu[0], pd_oe[1]}), 32'h00000000);
        @(posedge clk_i);
        txd <= 1'b0;
        wt(1);
        chk("open drain transmit low", 32'({pd_oe[1], pd_out[1]}), 32'h00000002);
        bus(pdfg_pkg::ADDR_D_FUNC, 1'b1, 8'h31);
        @(posedge clk_i);
        txd <= 1'b1;
        wt(1);
        chk("single wire loop", 32'(rxd), 32'h00000001);
        $display("test serial done");
        bus(pdfg_pkg::ADDR_G_DATA, 1'b1, 8'hA5);
        wt(1);
        chk("port g drive", 32'({pg_oe[6:0], pg_out[6:0]}), 32'h00003FA5);
        bus(pdfg_pkg::ADDR_G_CSEN, 1'b1, 8'h80);
        wt(1);
        chk("chip select enable", 32'(pg_oe[7]), 32'h00000001);
        $display("test port g done");
        results();
    end
endmodule : test_port_d_f_g_pin_control
`default_nettype wire
